//--- pkg/rpd_pkg.sv
// shared constants, register map and state type of the receive read clock phase deskew block
package rpd_pkg;
  // ==========================================================
  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] RPD_OFS_CTRL = 8'h00;
  localparam logic [7:0] RPD_OFS_TOTAL = 8'h04;
  localparam logic [7:0] RPD_OFS_STATUS = 8'h08;
  localparam logic [7:0] RPD_OFS_RUNS = 8'h0c;
  localparam logic [7:0] RPD_OFS_CLKSEL = 8'h10;
  // ==========================================================
  // control register fields
  localparam int RPD_CTRL_ENABLE = 0;
  localparam int RPD_CTRL_INC = 1;
  localparam int RPD_CTRL_START = 2;
  localparam int RPD_CTRL_FIFO_RST = 3;
  localparam logic RPD_ENABLE_RST = 1'b1;
  localparam logic RPD_INC_RST = 1'b1;
  // ==========================================================
  // status register fields
  localparam int RPD_ST_BUSY = 0;
  localparam int RPD_ST_DONE = 1;
  localparam int RPD_ST_LOCKED = 2;
  localparam int RPD_ST_ALL_COMPLETE = 3;
  localparam int RPD_ST_TIMEOUT = 4;
  localparam int RPD_ST_STATE_LSB = 8;
  localparam int RPD_ST_STEPS_LSB = 16;
  // ==========================================================
  // clock source select encoding: 0 fabric clock, 1 locally buffered clock
  localparam logic RPD_SRC_FABRIC = 1'b0;
  localparam logic RPD_SRC_BUFFERED = 1'b1;
  localparam int RPD_CLKSEL_TX_LSB = 0;
  localparam int RPD_CLKSEL_RX_LSB = 4;
  // ==========================================================
  // timing: resolution of one step is one fifty-sixth of the oscillator period
  localparam int RPD_STEPS_PER_VCO_PERIOD = 56;
  localparam int RPD_TIMEOUT_DEF = 1024;
  localparam int RPD_STEP_TOTAL_DEF = 8;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    RPD_IDLE,
    RPD_WAIT_LOCK,
    RPD_STEP_REQ,
    RPD_STEP_WAIT,
    RPD_DONE
  } rpd_state_t;
endpackage

//--- pkg/rpd_trig_if.sv
// start indication passed from the lane completion detector to the sequencer
`timescale 1ns/100ps
interface rpd_trig_if;
  logic all_complete; // every lane reports receive reset complete
  logic rise_pulse; // one cycle on the low-to-high change of all_complete
  modport src (output all_complete, output rise_pulse);
  modport dst (input all_complete, input rise_pulse);
endinterface

//--- rtl/rpd_deskew.sv
// receive read clock phase deskew sequencer with register port
// ==========================================================
// Overview of operation
// [RL1] adjustment starts only when every lane reports receive reset complete
// [RL2] every new rise of group completion restarts the whole adjustment
// [RL3] state machine steps the phase over the manager's phase-shift port, 1/56 period each
// [RL4] integrator sets manager multiply and divide, fixing the step resolution
// [RL5] integrator programs step total as shift over resolution, rounded up
// [RL6] controlling logic pulses the elastic buffer reset once after manager lock; here it pulses on each software request while locked
// [RL7] retraining resets the buffer; the resulting completion rise reruns adjustment
// [RL8] buffered transmit clock zero is used only when its select picks it
// [RL9] each buffered receive clock is used only when its select picks it
// [RL10] one step request at a time, wait for done, count to total
// [RL11] no steps before lock; losing lock abandons the run and waits again
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module rpd_deskew import rpd_pkg::*; #(
  parameter int NUM_LANES = 4,
  parameter int STEP_W = 16,
  parameter int STEP_TOTAL_DEF = RPD_STEP_TOTAL_DEF,
  parameter int TIMEOUT_CYCLES = RPD_TIMEOUT_DEF,
  parameter logic TX_SEL_0 = RPD_SRC_FABRIC,
  parameter logic TX_SEL_1 = RPD_SRC_FABRIC,
  parameter logic [3:0] RX_SEL = {4{RPD_SRC_FABRIC}}
) (
  input wire logic mclk, // 40 MHz system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [NUM_LANES-1:0] rx_reset_complete, // per-lane completion levels
  input wire logic cm_locked, // clock manager lock
  input wire logic cm_step_done, // clock manager step acknowledge, one cycle
  output logic cm_step_en, // step request, one cycle
  output logic cm_step_inc, // step direction, 1 advances the phase
  output logic rx_elastic_buffer_reset, // receive buffer reset pulse
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata // read data, cycle after the strobe
);
  localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYCLES - 1);

  // group completion carrier from the lane detector
  rpd_trig_if trig ();

  // sequencer state, software controls and progress
  rpd_state_t state;
  logic ctl_enable;
  logic ctl_inc;
  logic [STEP_W-1:0] step_total;
  logic [STEP_W-1:0] step_cnt;
  logic [15:0] run_cnt;
  logic [TMO_W-1:0] tmo_cnt;
  logic pending;
  logic timeout_err;
  logic done_flag;

  // decoded strobes and conditions
  logic wr_ctrl;
  logic wr_status;
  logic wr_total;
  logic sw_start;
  logic tmo_hit;
  logic step_last;
  logic run_finish;

  // read data selected ahead of the output register
  logic [31:0] next_rdata;

  initial begin
    if (NUM_LANES < 1 || NUM_LANES > 4) $error("rpd_deskew: NUM_LANES must be 1 to 4");
    if (STEP_W < 1 || STEP_W > 16) $error("rpd_deskew: STEP_W must be 1 to 16");
    if (TIMEOUT_CYCLES < 2) $error("rpd_deskew: TIMEOUT_CYCLES must be at least 2");
    if (STEP_TOTAL_DEF >= (1 << STEP_W)) $error("rpd_deskew: STEP_TOTAL_DEF too wide");
  end

  // ==========================================================
  // group completion detector
  rpd_trig_detect #(
    .NUM_LANES(NUM_LANES)
  ) u_trig (
    .mclk(mclk),
    .arst_n(arst_n),
    .rx_reset_complete(rx_reset_complete),
    .trig(trig)
  );

  // ==========================================================
  // register decode
  assign wr_ctrl = reg_wr && (reg_addr == RPD_OFS_CTRL);
  assign wr_status = reg_wr && (reg_addr == RPD_OFS_STATUS);
  assign wr_total = reg_wr && (reg_addr == RPD_OFS_TOTAL);
  assign sw_start = wr_ctrl && reg_wdata[RPD_CTRL_START];
  assign step_last = (step_cnt + STEP_W'(1)) == step_total;
  assign tmo_hit = (state == RPD_STEP_WAIT) && (tmo_cnt == TMO_LAST) &&
                   cm_locked && !cm_step_done; // lock loss abandons, it is no timeout

  // a run ends on the answer to its last step, unless a restart is waiting
  assign run_finish = (state == RPD_STEP_WAIT) && cm_step_done && cm_locked && step_last &&
                      !pending;

  // ==========================================================
  // software controls
  // control bits steering the sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_enable <= RPD_ENABLE_RST;
      ctl_inc <= RPD_INC_RST;
    end else if (wr_ctrl) begin
      ctl_enable <= reg_wdata[RPD_CTRL_ENABLE];
      ctl_inc <= reg_wdata[RPD_CTRL_INC];
    end
  end

  // step total programmed by software
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      step_total <= STEP_W'(STEP_TOTAL_DEF);
    end else if (wr_total) begin
      step_total <= reg_wdata[STEP_W-1:0]; // RL5
    end
  end

  // ==========================================================
  // elastic buffer reset
  // elastic buffer reset: one-cycle pulse on software request, only while locked
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_elastic_buffer_reset <= 1'b0;
    end else begin
      rx_elastic_buffer_reset <= wr_ctrl && reg_wdata[RPD_CTRL_FIFO_RST] && cm_locked; // RL6
    end
  end

  // ==========================================================
  // start request held until the sequencer can act on it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
    end else if ((trig.rise_pulse || sw_start) && ctl_enable) begin
      pending <= 1'b1; // RL2
    end else if (!ctl_enable) begin
      pending <= 1'b0;
    end else if (state == RPD_WAIT_LOCK) begin
      pending <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= RPD_IDLE;
    end else begin
      unique case (state)
        RPD_IDLE, RPD_DONE: begin
          if (pending && trig.all_complete) begin
            state <= RPD_WAIT_LOCK; // RL1
          end
        end
        RPD_WAIT_LOCK: begin
          if (!ctl_enable) begin
            state <= RPD_IDLE;
          end else if (cm_locked && trig.all_complete) begin
            state <= (step_total == '0) ? RPD_DONE : RPD_STEP_REQ; // RL11
          end
        end
        RPD_STEP_REQ: begin
          state <= cm_locked ? RPD_STEP_WAIT : RPD_WAIT_LOCK; // RL10 RL11
        end
        RPD_STEP_WAIT: begin
          if (!cm_locked) begin
            state <= RPD_WAIT_LOCK; // RL11
          end else if (cm_step_done) begin
            if (pending) begin
              state <= RPD_WAIT_LOCK; // RL2
            end else if (step_last) begin
              state <= RPD_DONE; // RL10
            end else begin
              state <= RPD_STEP_REQ; // RL10
            end
          end else if (tmo_hit) begin
            state <= RPD_IDLE;
          end
        end
        default: begin
          state <= RPD_IDLE; // unused codes fall back to idle
        end
      endcase
    end
  end

  // ==========================================================
  // step port towards the clock manager
  // step request and direction, one request per visit to the request state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cm_step_en <= 1'b0;
      cm_step_inc <= RPD_INC_RST;
    end else begin
      cm_step_en <= (state == RPD_STEP_REQ) && cm_locked; // RL3 RL10
      if (state == RPD_WAIT_LOCK) begin
        cm_step_inc <= ctl_inc;
      end
    end
  end

  // ==========================================================
  // counters, watchdog and status flags
  // steps acknowledged in the current run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt <= '0;
    end else if (state == RPD_WAIT_LOCK) begin
      step_cnt <= '0; // RL11
    end else if (state == RPD_STEP_WAIT && cm_step_done && cm_locked) begin
      step_cnt <= step_cnt + STEP_W'(1); // RL10
    end
  end

  // acknowledge watchdog while a step is outstanding
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_cnt <= '0;
    end else if (state == RPD_STEP_WAIT) begin
      tmo_cnt <= tmo_cnt + TMO_W'(1);
    end else begin
      tmo_cnt <= '0;
    end
  end

  // sticky timeout flag, write one to clear, a new timeout wins over the clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_err <= 1'b0;
    end else if (tmo_hit) begin
      timeout_err <= 1'b1;
    end else if (wr_status && reg_wdata[RPD_ST_TIMEOUT]) begin
      timeout_err <= 1'b0;
    end
  end

  // completed runs, counted once per finished run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= '0;
    end else if (run_finish) begin
      run_cnt <= run_cnt + 16'h0001; // RL10
    end
  end

  // done indication, held until the next run begins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done_flag <= 1'b0;
    end else if (state == RPD_WAIT_LOCK) begin
      done_flag <= 1'b0;
    end else if (run_finish) begin
      done_flag <= 1'b1;
    end
  end

  // ==========================================================
  // read data, valid in the cycle after the read strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_addr)
      RPD_OFS_CTRL: begin
        next_rdata[RPD_CTRL_ENABLE] = ctl_enable;
        next_rdata[RPD_CTRL_INC] = ctl_inc;
      end
      RPD_OFS_TOTAL: begin
        next_rdata[STEP_W-1:0] = step_total;
      end
      RPD_OFS_STATUS: begin
        next_rdata[RPD_ST_BUSY] = (state != RPD_IDLE) && (state != RPD_DONE);
        next_rdata[RPD_ST_DONE] = done_flag;
        next_rdata[RPD_ST_LOCKED] = cm_locked;
        next_rdata[RPD_ST_ALL_COMPLETE] = trig.all_complete;
        next_rdata[RPD_ST_TIMEOUT] = timeout_err;
        next_rdata[RPD_ST_STATE_LSB +: 3] = state;
        next_rdata[RPD_ST_STEPS_LSB +: STEP_W] = step_cnt;
      end
      RPD_OFS_RUNS: begin
        next_rdata[15:0] = run_cnt;
      end
      RPD_OFS_CLKSEL: begin
        next_rdata[RPD_CLKSEL_TX_LSB] = TX_SEL_0; // RL8
        next_rdata[RPD_CLKSEL_TX_LSB + 1] = TX_SEL_1;
        next_rdata[RPD_CLKSEL_RX_LSB +: 4] = RX_SEL; // RL9
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data register, zero outside the answering cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

//--- rtl/rpd_trig_detect.sv
// detects that every lane has completed receive reset and marks each new completion
`timescale 1ns/100ps
module rpd_trig_detect import rpd_pkg::*; #(
  parameter int NUM_LANES = 4
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [NUM_LANES-1:0] rx_reset_complete, // per-lane completion levels
  rpd_trig_if.src trig // start indication to the sequencer
);
  logic all_q;

  initial begin
    if (NUM_LANES < 1) $error("rpd_trig_detect: NUM_LANES must be at least 1");
  end

  // ==========================================================
  // completion of the whole group
  assign trig.all_complete = &rx_reset_complete; // RL1

  // previous level, cleared at reset so a group already complete starts one run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      all_q <= 1'b0;
    end else begin
      all_q <= trig.all_complete;
    end
  end

  // every new low-to-high change starts the sequence again
  assign trig.rise_pulse = trig.all_complete & ~all_q; // RL2 RL7
endmodule

//--- testbench/rpd_cm_model.sv
// behavioural clock manager: lock output and phase-shift port
`timescale 1ns/100ps
module rpd_cm_model (
  input wire logic mclk, // clock
  input wire logic arst_n, // reset
  input wire logic lock_req, // bench asks for lock
  input wire logic [3:0] delay, // answer delay in cycles
  input wire logic cm_step_en, // step request
  input wire logic cm_step_inc, // direction
  output logic cm_locked, // lock
  output logic cm_step_done, // step answer
  output int phase, // phase in 1/56 period units
  output int steps // steps answered
);
  logic busy;
  logic [3:0] left;
  assign cm_locked = lock_req;
  // ==========================================================
  // one step in flight; losing lock drops it unanswered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      left <= 4'h0;
      cm_step_done <= 1'b0;
      phase <= 0;
      steps <= 0;
    end else begin
      cm_step_done <= 1'b0;
      if (!cm_locked) begin
        busy <= 1'b0;
      end else if (cm_step_en) begin
        busy <= 1'b1;
        left <= delay;
      end else if (busy && left != 4'h0) begin
        left <= left - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        cm_step_done <= 1'b1;
        steps <= steps + 1;
        phase <= (phase + (cm_step_inc ? 1 : 55)) % 56;
      end
    end
  end
endmodule

//--- testbench/rpd_deskew_checker.sv
// port assertions for the deskew sequencer
`timescale 1ns/100ps
module rpd_deskew_checker import rpd_pkg::*; #(
  parameter int NUM_LANES = 4
) (
  input wire logic mclk, // clock
  input wire logic arst_n, // reset
  input wire logic [NUM_LANES-1:0] rx_reset_complete, // lanes
  input wire logic cm_locked, // lock
  input wire logic cm_step_done, // step answer
  input wire logic cm_step_en, // step request
  input wire logic cm_step_inc, // direction
  input wire logic rx_elastic_buffer_reset, // buffer reset
  input wire logic [7:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata // read data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic seen_all;
  logic owed;
  // ==========================================================
  // history: group completion seen, step awaiting its answer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) seen_all <= 1'b0;
    else if (&rx_reset_complete) seen_all <= 1'b1;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) owed <= 1'b0;
    else if (cm_step_done || !cm_locked) owed <= 1'b0;
    else if (cm_step_en) owed <= 1'b1;
  end
  // ==========================================================
  // assertions
  AST_STEP_LOCKED: assert property (cm_step_en |-> $past(cm_locked))
    else $error("step request without lock");
  AST_STEP_AFTER_ALL: assert property (cm_step_en |-> seen_all)
    else $error("step before all lanes complete");
  AST_ONE_OWED: assert property (cm_step_en |-> !owed)
    else $error("second step before answer");
  AST_STEP_PULSE: assert property (cm_step_en |=> !cm_step_en)
    else $error("step request longer than one cycle");
  AST_READ_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  AST_BUF_PULSE: assert property (rx_elastic_buffer_reset |=> !rx_elastic_buffer_reset)
    else $error("buffer reset longer than one cycle");
  AST_BUF_CAUSE: assert property (rx_elastic_buffer_reset |-> $past(reg_wr && cm_locked
    && reg_addr == RPD_OFS_CTRL && reg_wdata[RPD_CTRL_FIFO_RST]))
    else $error("buffer reset without locked request");
  AST_RISE_STEPS: assert property ($rose(&rx_reset_complete) && cm_locked
    |-> ##[1:24] cm_step_en)
    else $error("completion rise did not start stepping");
  // ==========================================================
  // covers
  C_LOSS: cover property (owed && !cm_locked);
  C_DEC: cover property (cm_step_en && !cm_step_inc);
  C_BUF: cover property (rx_elastic_buffer_reset);
endmodule
bind rpd_deskew rpd_deskew_checker #(.NUM_LANES(NUM_LANES)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .rx_reset_complete(rx_reset_complete),
  .cm_locked(cm_locked), .cm_step_done(cm_step_done), .cm_step_en(cm_step_en),
  .cm_step_inc(cm_step_inc), .rx_elastic_buffer_reset(rx_elastic_buffer_reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

//--- testbench/tb.sv
// self-checking bench for the deskew sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb import rpd_pkg::*;;
  localparam int TOT = (100 * 56 + 1599) / 1600; // 100 ps over 1600/56 ps, rounded up
  logic mclk, arst_n, lock_req, cm_locked, cm_step_done, cm_step_en, cm_step_inc;
  logic buf_rst, reg_wr, reg_rd;
  logic [3:0] lanes, delay;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int phase, steps, bad_count = 0, checked = 0, cycles = 0;
  rpd_deskew #(.TIMEOUT_CYCLES(16), .TX_SEL_0(RPD_SRC_BUFFERED), .RX_SEL(4'ha)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .rx_reset_complete(lanes), .cm_locked(cm_locked),
    .cm_step_done(cm_step_done), .cm_step_en(cm_step_en), .cm_step_inc(cm_step_inc),
    .rx_elastic_buffer_reset(buf_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rpd_cm_model u_cm (.mclk(mclk), .arst_n(arst_n), .lock_req(lock_req), .delay(delay),
    .cm_step_en(cm_step_en), .cm_step_inc(cm_step_inc), .cm_locked(cm_locked),
    .cm_step_done(cm_step_done), .phase(phase), .steps(steps));
  // ==========================================================
  // register port cycles
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    repeat (4) @(posedge mclk);
    do begin
      rd_reg(RPD_OFS_STATUS);
      n++;
    end while (rv[10:8] !== 3'h4 && n < 200);
    `CHK("finish", 3'h4, rv[10:8])
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd_reg(RPD_OFS_CTRL);
    `CHK("ctrl", 32'h3, rv)
    rd_reg(RPD_OFS_TOTAL);
    `CHK("total", 32'h8, rv)
    rd_reg(RPD_OFS_CLKSEL);
    `CHK("clksel", 32'ha1, rv)
    rd_reg(8'h20);
    `CHK("unmapped", 32'h0, rv)
  endtask
  task automatic t_first();
    wr_reg(RPD_OFS_TOTAL, TOT);
    @(posedge mclk) lanes <= 4'h7;
    repeat (30) @(posedge mclk);
    `CHK("partial", 0, steps)
    lanes <= 4'hf;
    wait_done();
    `CHK("steps", TOT, steps)
    `CHK("count", TOT, rv[31:16])
    `CHK("phase", TOT, phase)
    `CHK("flags", 5'h0e, rv[4:0])
  endtask
  task automatic t_retrig();
    @(posedge mclk) lanes <= 4'hd;
    wr_reg(RPD_OFS_CTRL, 32'hb);
    #1 `CHK("bufrst", 1'b1, buf_rst)
    @(posedge mclk);
    #1 `CHK("bufend", 1'b0, buf_rst)
    @(posedge mclk) lanes <= 4'hf;
    wait_done();
    `CHK("rerun", 2 * TOT, steps)
    rd_reg(RPD_OFS_RUNS);
    `CHK("runs", 32'h2, rv)
  endtask
  task automatic t_lock();
    int n;
    n = 0;
    delay <= 4'h6;
    wr_reg(RPD_OFS_CTRL, 32'h5);
    while (cm_step_en !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK("stepreq", 1'b1, cm_step_en)
    `CHK("dir", 1'b0, cm_step_inc)
    @(posedge mclk) lock_req <= 1'b0;
    repeat (20) @(posedge mclk);
    `CHK("unlocked", 2 * TOT, steps)
    rd_reg(RPD_OFS_STATUS);
    `CHK("state", 3'h1, rv[10:8])
    @(posedge mclk) lock_req <= 1'b1;
    wait_done();
    `CHK("relock", 3 * TOT, steps)
    `CHK("back", TOT, phase)
  endtask
  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // clock, hang ceiling and main sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    arst_n = 1'b0;
    lanes = 4'h0;
    lock_req = 1'b1;
    delay = 4'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_first();
    t_retrig();
    t_lock();
    summarize();
  end
endmodule
